// ---- rtl/ppi_top.sv ----
// ppi_top: pad pull-up control, port E timer/gpio sharing, can transmit pad
// and external request conditioning, with an AXI4-Lite register slave.
// assumes pad inputs synchronous to aclk except the two request inputs.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module ppi_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [ppi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ppi_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer side: bit 0..1 timer C ch0..1, bit 2..5 timer D ch0..3
    input wire logic [ppi_pkg::NPE-1:0] timer_out,
    input wire logic [ppi_pkg::NPE-1:0] timer_oe,
    output logic [ppi_pkg::NPE-1:0] timer_in,
    // port E pads, bit 0 is port_e_bit8 .. bit 5 is port_e_bit13
    input wire logic [ppi_pkg::NPE-1:0] port_e_in,
    output logic [ppi_pkg::NPE-1:0] port_e_out,
    output logic [ppi_pkg::NPE-1:0] port_e_oe_n,
    output logic [ppi_pkg::NPE-1:0] port_e_pu_en,
    // can transmit pad
    input wire logic can_tx_data,
    output logic can_tx_out,
    output logic can_tx_oe_n,
    output logic can_tx_pu_en,
    // external requests: request pins active low, ext_req and ext_wake active high
    input wire logic ext_request_a,
    input wire logic ext_request_b,
    input wire logic low_power,
    output logic ext_request_pu_en,
    output logic [1:0] ext_req,
    output logic ext_wake,
    output logic irq
);
    // configuration registers
    logic [ppi_pkg::NPE-1:0] pe_func_ff;
    logic [ppi_pkg::NPE-1:0] nxt_pe_func;
    logic [ppi_pkg::NPE-1:0] pe_dir_ff;
    logic [ppi_pkg::NPE-1:0] nxt_pe_dir;
    logic [ppi_pkg::NPE-1:0] pe_out_ff;
    logic [ppi_pkg::NPE-1:0] nxt_pe_out;
    logic [ppi_pkg::NPE-1:0] pe_od_ff;
    logic [ppi_pkg::NPE-1:0] nxt_pe_od;
    logic [ppi_pkg::NPE-1:0] port_e_pullup_bits_ff;
    logic [ppi_pkg::NPE-1:0] nxt_port_e_pullup_bits;
    logic gpio_pullup_enable_bits_ff;
    logic nxt_gpio_pullup_enable_bits;
    logic system_pullup_disable_reg_ff;
    logic nxt_system_pullup_disable_reg;
    logic [1:0] irq_cfg_ff;
    logic [1:0] nxt_irq_cfg;
    logic [1:0] int_stat_ff;
    logic [1:0] nxt_int_stat;
    logic [1:0] int_mask_ff;
    logic [1:0] nxt_int_mask;
    logic irq_ff;
    logic nxt_irq;

    // bus state
    logic aw_held_ff;
    logic nxt_aw_held;
    logic [ppi_pkg::ADDR_W-1:0] aw_addr_ff;
    logic [ppi_pkg::ADDR_W-1:0] nxt_aw_addr;
    logic w_held_ff;
    logic nxt_w_held;
    logic [7:0] w_data_ff;
    logic [7:0] nxt_w_data;
    logic w_strb0_ff;
    logic nxt_w_strb0;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic wr_fire;
    logic rd_fire;
    logic stat_rd;

    // pad state
    ppi_pkg::ppi_pin_cfg_s pin_cfg [ppi_pkg::NPAD];
    ppi_pkg::ppi_pad_s pad_dec;
    ppi_pkg::ppi_pad_s pad_ff;
    logic [ppi_pkg::NPE-1:0] pin_in_ff;
    logic [ppi_pkg::NPE-1:0] nxt_pin_in;
    logic [1:0] req;
    logic [1:0] wake;
    logic ext_request_pu_ff;
    logic nxt_ext_request_pu;

    function automatic logic addr_hit(input logic [ppi_pkg::ADDR_W-1:0] a,
                                      input logic [5:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic mapped(input logic [ppi_pkg::ADDR_W-1:0] a);
        return a[1:0] == 2'h0 && a <= ppi_pkg::OFS_PIN_STATE;
    endfunction

    // write channel: address and data taken in either order, answered together
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign rd_fire = s_axi_arvalid && !rvalid_ff;
    assign stat_rd = rd_fire && addr_hit(s_axi_araddr, ppi_pkg::OFS_INT_STAT);

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb0 = w_strb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && !aw_held_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata[7:0];
            nxt_w_strb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = mapped(aw_addr_ff) ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // register writes; only byte lane 0 carries bits
    always_comb begin
        nxt_pe_func = pe_func_ff;
        nxt_pe_dir = pe_dir_ff;
        nxt_pe_out = pe_out_ff;
        nxt_pe_od = pe_od_ff;
        nxt_port_e_pullup_bits = port_e_pullup_bits_ff;
        nxt_gpio_pullup_enable_bits = gpio_pullup_enable_bits_ff;
        nxt_system_pullup_disable_reg = system_pullup_disable_reg_ff;
        nxt_irq_cfg = irq_cfg_ff;
        nxt_int_mask = int_mask_ff;
        if (wr_fire && w_strb0_ff) begin
            unique case (aw_addr_ff)
                ppi_pkg::OFS_PE_FUNC: nxt_pe_func = w_data_ff[ppi_pkg::NPE-1:0];
                ppi_pkg::OFS_PE_DIR: nxt_pe_dir = w_data_ff[ppi_pkg::NPE-1:0];
                ppi_pkg::OFS_PE_OUT: nxt_pe_out = w_data_ff[ppi_pkg::NPE-1:0];
                ppi_pkg::OFS_PE_OD: nxt_pe_od = w_data_ff[ppi_pkg::NPE-1:0];
                ppi_pkg::OFS_PE_PU: nxt_port_e_pullup_bits = w_data_ff[ppi_pkg::NPE-1:0];
                ppi_pkg::OFS_GPIO_PU: begin
                    nxt_gpio_pullup_enable_bits = w_data_ff[ppi_pkg::GPIO_PU_CAN_BIT];
                end
                ppi_pkg::OFS_SYS_PUD: begin
                    nxt_system_pullup_disable_reg = w_data_ff[ppi_pkg::SYS_PUD_IRQ_BIT];
                end
                ppi_pkg::OFS_IRQ_CFG: nxt_irq_cfg = w_data_ff[1:0];
                ppi_pkg::OFS_INT_MASK: nxt_int_mask = w_data_ff[1:0];
                default: begin
                end
            endcase
        end
    end

    // read channel: one cycle from arvalid to rvalid
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = 32'h0;
            nxt_rresp = mapped(s_axi_araddr) ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                ppi_pkg::OFS_PE_FUNC: nxt_rdata[ppi_pkg::NPE-1:0] = pe_func_ff;
                ppi_pkg::OFS_PE_DIR: nxt_rdata[ppi_pkg::NPE-1:0] = pe_dir_ff;
                ppi_pkg::OFS_PE_OUT: nxt_rdata[ppi_pkg::NPE-1:0] = pe_out_ff;
                ppi_pkg::OFS_PE_OD: nxt_rdata[ppi_pkg::NPE-1:0] = pe_od_ff;
                ppi_pkg::OFS_PE_PU: nxt_rdata[ppi_pkg::NPE-1:0] = port_e_pullup_bits_ff;
                ppi_pkg::OFS_GPIO_PU: begin
                    nxt_rdata[ppi_pkg::GPIO_PU_CAN_BIT] = gpio_pullup_enable_bits_ff;
                end
                ppi_pkg::OFS_SYS_PUD: begin
                    nxt_rdata[ppi_pkg::SYS_PUD_IRQ_BIT] = system_pullup_disable_reg_ff;
                end
                ppi_pkg::OFS_IRQ_CFG: nxt_rdata[1:0] = irq_cfg_ff;
                ppi_pkg::OFS_INT_STAT: nxt_rdata[1:0] = int_stat_ff;
                ppi_pkg::OFS_INT_MASK: nxt_rdata[1:0] = int_mask_ff;
                ppi_pkg::OFS_PIN_STATE: begin
                    nxt_rdata[ppi_pkg::NPE-1:0] = pin_in_ff;
                    nxt_rdata[ppi_pkg::PS_REQ_LSB+1:ppi_pkg::PS_REQ_LSB] = req;
                    nxt_rdata[ppi_pkg::PS_LP_BIT] = low_power;
                end
                default: begin
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // sticky status: a request in the clearing read's cycle stays set
    always_comb begin
        nxt_int_stat = int_stat_ff;
        if (stat_rd) begin
            nxt_int_stat = 2'h0;
        end
        nxt_int_stat = nxt_int_stat | req;
        nxt_irq = |(nxt_int_stat & nxt_int_mask);
    end

    // pad configuration; timers drive push-pull, gpio may choose open-drain
    always_comb begin
        for (int i = 0; i < ppi_pkg::NPE; i++) begin
            // a set function bit hands the pin to gpio, reset leaves the timer on it
            pin_cfg[i].drive_en = pe_func_ff[i] ? pe_dir_ff[i] : timer_oe[i];
            pin_cfg[i].drive_val = pe_func_ff[i] ? pe_out_ff[i] : timer_out[i];
            pin_cfg[i].od_mode = pe_func_ff[i] & pe_od_ff[i];
            pin_cfg[i].pu_allow = port_e_pullup_bits_ff[i];
        end
        pin_cfg[ppi_pkg::CAN_IDX].drive_en = 1'b1;
        pin_cfg[ppi_pkg::CAN_IDX].drive_val = can_tx_data;
        pin_cfg[ppi_pkg::CAN_IDX].od_mode = 1'b1;
        pin_cfg[ppi_pkg::CAN_IDX].pu_allow = gpio_pullup_enable_bits_ff;
        nxt_pin_in = port_e_in;
        nxt_ext_request_pu = ~system_pullup_disable_reg_ff;
    end

    ppi_pull_ctl u_pull (
        .cfg(pin_cfg),
        .pad(pad_dec)
    );

    ppi_irq_cond u_req_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .req_pin_n(ext_request_a),
        .edge_mode(irq_cfg_ff[ppi_pkg::REQ_A_BIT]),
        .low_power(low_power),
        .req(req[ppi_pkg::REQ_A_BIT]),
        .wake(wake[ppi_pkg::REQ_A_BIT])
    );

    ppi_irq_cond u_req_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .req_pin_n(ext_request_b),
        .edge_mode(irq_cfg_ff[ppi_pkg::REQ_B_BIT]),
        .low_power(low_power),
        .req(req[ppi_pkg::REQ_B_BIT]),
        .wake(wake[ppi_pkg::REQ_B_BIT])
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff <= 1'b0;
            w_data_ff <= 8'h00;
            w_strb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ppi_pkg::RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= ppi_pkg::RESP_OKAY;
        end else if (ce) begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_data_ff <= nxt_w_data;
            w_strb0_ff <= nxt_w_strb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pe_func_ff <= ppi_pkg::RST_PE_FUNC;
            pe_dir_ff <= ppi_pkg::RST_PE_DIR;
            pe_out_ff <= ppi_pkg::RST_PE_OUT;
            pe_od_ff <= ppi_pkg::RST_PE_OD;
            port_e_pullup_bits_ff <= ppi_pkg::RST_PE_PU;
            gpio_pullup_enable_bits_ff <= ppi_pkg::RST_CAN_PU;
            system_pullup_disable_reg_ff <= ppi_pkg::RST_SYS_PUD_IRQ;
            irq_cfg_ff <= ppi_pkg::RST_IRQ_CFG;
            int_mask_ff <= ppi_pkg::RST_INT_MASK;
            int_stat_ff <= 2'h0;
            irq_ff <= 1'b0;
        end else if (ce) begin
            pe_func_ff <= nxt_pe_func;
            pe_dir_ff <= nxt_pe_dir;
            pe_out_ff <= nxt_pe_out;
            pe_od_ff <= nxt_pe_od;
            port_e_pullup_bits_ff <= nxt_port_e_pullup_bits;
            gpio_pullup_enable_bits_ff <= nxt_gpio_pullup_enable_bits;
            system_pullup_disable_reg_ff <= nxt_system_pullup_disable_reg;
            irq_cfg_ff <= nxt_irq_cfg;
            int_mask_ff <= nxt_int_mask;
            int_stat_ff <= nxt_int_stat;
            irq_ff <= nxt_irq;
        end
    end

    // pads start as inputs with pull-ups on, can pad released high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_ff.out <= '0;
            pad_ff.oe_n <= '1;
            pad_ff.pu_en <= '1;
            pin_in_ff <= '0;
            ext_request_pu_ff <= 1'b1;
        end else if (ce) begin
            pad_ff <= pad_dec;
            pin_in_ff <= nxt_pin_in;
            ext_request_pu_ff <= nxt_ext_request_pu;
        end
    end

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign timer_in = pin_in_ff;
    assign port_e_out = pad_ff.out[ppi_pkg::NPE-1:0];
    assign port_e_oe_n = pad_ff.oe_n[ppi_pkg::NPE-1:0];
    assign port_e_pu_en = pad_ff.pu_en[ppi_pkg::NPE-1:0];
    assign can_tx_out = pad_ff.out[ppi_pkg::CAN_IDX];
    assign can_tx_oe_n = pad_ff.oe_n[ppi_pkg::CAN_IDX];
    assign can_tx_pu_en = pad_ff.pu_en[ppi_pkg::CAN_IDX];
    assign ext_request_pu_en = ext_request_pu_ff;
    assign ext_req = req;
    // the only unregistered output: it must work with the clock stopped
    assign ext_wake = |wake;
    assign irq = irq_ff;
endmodule

// ---- rtl/ppi_pkg.sv ----
// ppi_pkg: constants and carriers of the pad pull-up block.
// assumes a single 250 MHz clock domain and a 32-bit AXI4-Lite register bus.
package ppi_pkg;
    localparam int ADDR_W = 6;
    localparam int NPE = 6;
    localparam int NPAD = 7;
    localparam int CAN_IDX = 6;
    localparam int SYNC_STAGES = 2;
    localparam real CLK_PERIOD_NS = 4.0;

    // register byte offsets
    localparam logic [5:0] OFS_PE_FUNC = 6'h00;
    localparam logic [5:0] OFS_PE_DIR = 6'h04;
    localparam logic [5:0] OFS_PE_OUT = 6'h08;
    localparam logic [5:0] OFS_PE_OD = 6'h0c;
    localparam logic [5:0] OFS_PE_PU = 6'h10;
    localparam logic [5:0] OFS_GPIO_PU = 6'h14;
    localparam logic [5:0] OFS_SYS_PUD = 6'h18;
    localparam logic [5:0] OFS_IRQ_CFG = 6'h1c;
    localparam logic [5:0] OFS_INT_STAT = 6'h20;
    localparam logic [5:0] OFS_INT_MASK = 6'h24;
    localparam logic [5:0] OFS_PIN_STATE = 6'h28;

    // reset values
    localparam logic [5:0] RST_PE_FUNC = 6'h00;
    localparam logic [5:0] RST_PE_DIR = 6'h00;
    localparam logic [5:0] RST_PE_OUT = 6'h00;
    localparam logic [5:0] RST_PE_OD = 6'h00;
    localparam logic [5:0] RST_PE_PU = 6'h3f;
    localparam logic RST_CAN_PU = 1'h1;
    localparam logic RST_SYS_PUD_IRQ = 1'h0;
    localparam logic [1:0] RST_IRQ_CFG = 2'h0;
    localparam logic [1:0] RST_INT_MASK = 2'h0;

    // field positions
    localparam int GPIO_PU_CAN_BIT = 0;
    localparam int SYS_PUD_IRQ_BIT = 0;
    localparam int REQ_A_BIT = 0;
    localparam int REQ_B_BIT = 1;
    localparam int PS_REQ_LSB = 6;
    localparam int PS_LP_BIT = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NPAD-1:0] out;
        logic [NPAD-1:0] oe_n;
        logic [NPAD-1:0] pu_en;
    } ppi_pad_s;

    typedef struct packed {
        logic drive_en;
        logic drive_val;
        logic od_mode;
        logic pu_allow;
    } ppi_pin_cfg_s;
endpackage

// ---- rtl/ppi_pull_ctl.sv ----
// ppi_pull_ctl: per-pad drive and pull-up decision, purely combinational.
// assumes the caller registers the result before it reaches the pads.
`timescale 1ns/10ps
module ppi_pull_ctl (
    input wire ppi_pkg::ppi_pin_cfg_s cfg [ppi_pkg::NPAD],
    output ppi_pkg::ppi_pad_s pad
);
    // open-drain only ever sinks; push-pull never needs the pull-up
    function automatic logic [2:0] decide(input ppi_pkg::ppi_pin_cfg_s c);
        logic [2:0] r;
        r = {1'b0, 1'b1, c.pu_allow};
        if (c.drive_en && c.od_mode) begin
            r = {1'b0, c.drive_val, c.drive_val & c.pu_allow};
        end else if (c.drive_en) begin
            r = {c.drive_val, 1'b0, 1'b0};
        end
        return r;
    endfunction

    always_comb begin
        pad = '0;
        for (int i = 0; i < ppi_pkg::NPAD; i++) begin
            {pad.out[i], pad.oe_n[i], pad.pu_en[i]} = decide(cfg[i]);
        end
    end
endmodule

// ---- rtl/ppi_irq_cond.sv ----
// ppi_irq_cond: conditions one active-low external request input.
// assumes low_power is high only while the core clock may be stopped.
`timescale 1ns/10ps
module ppi_irq_cond (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic req_pin_n,
    input wire logic edge_mode,
    input wire logic low_power,
    output logic req,
    output logic wake
);
    logic [ppi_pkg::SYNC_STAGES-1:0] sync_ff;
    logic [ppi_pkg::SYNC_STAGES-1:0] nxt_sync;
    logic last_ff;
    logic nxt_last;
    logic req_ff;
    logic nxt_req;

    // no clock needed to see a low level while sleeping
    assign wake = low_power & ~req_pin_n;

    always_comb begin
        nxt_sync = {sync_ff[ppi_pkg::SYNC_STAGES-2:0], req_pin_n};
        nxt_last = sync_ff[ppi_pkg::SYNC_STAGES-1];
        // edge mode compares the second and third stages, never the first
        if (edge_mode) begin
            nxt_req = last_ff & ~sync_ff[ppi_pkg::SYNC_STAGES-1];
        end else begin
            nxt_req = ~sync_ff[ppi_pkg::SYNC_STAGES-1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_ff <= '1;
            last_ff <= 1'b1;
            req_ff <= 1'b0;
        end else if (ce) begin
            sync_ff <= nxt_sync;
            last_ff <= nxt_last;
            req_ff <= nxt_req;
        end
    end

    assign req = req_ff;
endmodule

// ---- tb/ppi_checker.sv ----
// ppi_checker: port-level properties of ppi_top.
// assumes checks matter only while ce is high.
`timescale 1ns/10ps
module ppi_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ppi_pkg::NPE-1:0] port_e_oe_n,
    input wire logic [ppi_pkg::NPE-1:0] port_e_pu_en,
    input wire logic can_tx_data,
    input wire logic can_tx_out,
    input wire logic can_tx_oe_n,
    input wire logic can_tx_pu_en,
    input wire logic ext_request_a,
    input wire logic ext_request_b,
    input wire logic low_power,
    input wire logic ext_request_pu_en,
    input wire logic [1:0] ext_req,
    input wire logic ext_wake,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);
    sequence s_b_take;
        s_axi_bvalid && s_axi_bready;
    endsequence
    sequence s_r_take;
        s_axi_rvalid && s_axi_rready;
    endsequence
    property p_b_close;
        s_b_take |=> !s_axi_bvalid;
    endproperty
    a_b_close: assert property (p_b_close) else $error("bvalid held");
    property p_r_close;
        s_r_take |=> !s_axi_rvalid;
    endproperty
    a_r_close: assert property (p_r_close) else $error("rvalid held");
    property p_can_low;
        $past(aresetn) && !$past(can_tx_data) |-> !can_tx_oe_n && !can_tx_pu_en && !can_tx_out;
    endproperty
    a_can_low: assert property (p_can_low) else $error("can pad low wrong");
    property p_drive_no_pu;
        ((~port_e_oe_n & port_e_pu_en) == 6'h00) && !(!can_tx_oe_n && can_tx_pu_en);
    endproperty
    a_drive_no_pu: assert property (p_drive_no_pu) else $error("pull-up on driven pad");
    property p_rst_pulls;
        $rose(aresetn) |-> can_tx_pu_en && ext_request_pu_en && (&port_e_pu_en) && (&port_e_oe_n);
    endproperty
    a_rst_pulls: assert property (p_rst_pulls) else $error("reset pad state");
    property p_wake;
        ext_wake == (low_power && !(ext_request_a && ext_request_b));
    endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_sync_a;
        $rose(ext_req[0]) && $past(aresetn, 3) |-> !$past(ext_request_a, 3);
    endproperty
    a_sync_a: assert property (p_sync_a) else $error("request a timing");
    property p_sync_b;
        $rose(ext_req[1]) && $past(aresetn, 3) |-> !$past(ext_request_b, 3);
    endproperty
    a_sync_b: assert property (p_sync_b) else $error("request b timing");
    property p_irq_cause;
        $rose(irq) && $past(aresetn) |-> ($past(ext_req) != 2'h0) || $rose(s_axi_bvalid);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule

bind ppi_top ppi_checker u_chk (.aclk, .aresetn, .ce, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .port_e_oe_n, .port_e_pu_en, .can_tx_data, .can_tx_out, .can_tx_oe_n, .can_tx_pu_en,
    .ext_request_a, .ext_request_b, .low_power, .ext_request_pu_en, .ext_req, .ext_wake, .irq);

// ---- tb/ppi_far_end.sv ----
// ppi_far_end: devices on the request pins and port E pads.
// assumes an undriven pad without pull-up floats.
`timescale 1ns/10ps
module ppi_far_end (
    input wire logic [ppi_pkg::NPE-1:0] port_e_out,
    input wire logic [ppi_pkg::NPE-1:0] port_e_oe_n,
    input wire logic [ppi_pkg::NPE-1:0] port_e_pu_en,
    output logic [ppi_pkg::NPE-1:0] port_e_in,
    output logic ext_request_a,
    output logic ext_request_b
);
    logic flt = 1'b0;
    initial ext_request_a = 1'b1;
    initial ext_request_b = 1'b1;
    // a floating pad wanders, so it never keeps a stale level
    always #3.1 flt = ~flt;
    assign port_e_in = (~port_e_oe_n & port_e_out) | (port_e_oe_n & (port_e_pu_en | {ppi_pkg::NPE{flt}}));
    // requests are unrelated to the clock; release returns to the pulled-up level
    task automatic pull(input int which, input realtime t);
        fork
            begin
                if (which == 0) ext_request_a = 1'b0;
                else ext_request_b = 1'b0;
                #t;
                if (which == 0) ext_request_a = 1'b1;
                else ext_request_b = 1'b1;
            end
        join_none
    endtask
endmodule

// ---- tb/ppi_top_tb_top.sv ----
// ppi_top_tb_top: register and pad tests of ppi_top.
// assumes ppi_far_end models the pads and request sources.
`timescale 1ns/10ps
module ppi_top_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, low_power = 1'b0, can_tx_data = 1'b1;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00, timer_out = 6'h00, timer_oe = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, ext_req;
    logic [5:0] timer_in, port_e_in, port_e_out, port_e_oe_n, port_e_pu_en;
    logic can_tx_out, can_tx_oe_n, can_tx_pu_en, ext_request_a, ext_request_b;
    logic ext_request_pu_en, ext_wake, irq;
    int error_cnt = 0, comparisons = 0;
    always #2 aclk = ~aclk;
    ppi_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .timer_out, .timer_oe, .timer_in, .port_e_in, .port_e_out, .port_e_oe_n,
        .port_e_pu_en, .can_tx_data, .can_tx_out, .can_tx_oe_n, .can_tx_pu_en, .ext_request_a,
        .ext_request_b, .low_power, .ext_request_pu_en, .ext_req, .ext_wake, .irq);
    ppi_far_end far (.port_e_out, .port_e_oe_n, .port_e_pu_en, .port_e_in, .ext_request_a, .ext_request_b);
    task automatic chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic pb;
        pb = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (pb) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                pb = 1'b0;
                s_axi_bready <= 1'b0;
                chk(s_axi_bresp, er);
            end
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic pr;
        pr = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (pr) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                pr = 1'b0;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, e);
                chk(s_axi_rresp, er);
            end
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic req_run(input int i, input realtime t, output int first, output int hits);
        first = 0;
        hits = 0;
        @(negedge aclk);
        #1.3 far.pull(i, t);
        for (int k = 1; k <= 16; k++) begin
            @(negedge aclk);
            if (ext_req[i] === 1'b1) hits++;
            if (ext_req[i] === 1'b1 && first == 0) first = k;
        end
    endtask
    initial begin
        repeat (4000) @(posedge aclk);
        error_cnt++;
        final_report();
    end
    initial begin
        int f, h;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(port_e_oe_n, 6'h3f);
        chk({can_tx_pu_en, can_tx_oe_n, ext_request_pu_en}, 3'h7);
        rd(ppi_pkg::OFS_PE_FUNC, 32'h0);
        rd(ppi_pkg::OFS_PE_PU, 32'h3f);
        rd(ppi_pkg::OFS_GPIO_PU, 32'h1);
        rd(ppi_pkg::OFS_SYS_PUD, 32'h0);
        rd(6'h2c, 32'h0, ppi_pkg::RESP_SLVERR);
        wr(6'h02, 32'hff, ppi_pkg::RESP_SLVERR);
        @(posedge aclk);
        timer_out <= 6'h2a;
        timer_oe <= 6'h1f;
        settle();
        chk({port_e_out[4:0], port_e_oe_n, port_e_pu_en}, 17'h0a820);
        chk(timer_in, 6'h2a);
        wr(ppi_pkg::OFS_PE_FUNC, 32'h3f);
        wr(ppi_pkg::OFS_PE_DIR, 32'h05);
        wr(ppi_pkg::OFS_PE_OUT, 32'h01);
        settle();
        chk({port_e_out[0], port_e_out[2], port_e_oe_n, port_e_pu_en}, 14'h2eba);
        wr(ppi_pkg::OFS_PE_PU, 32'h3e);
        wr(ppi_pkg::OFS_PE_OD, 32'h05);
        settle();
        chk({port_e_oe_n, port_e_pu_en}, 12'hefa);
        wr(ppi_pkg::OFS_PE_PU, 32'h3f);
        settle();
        chk(port_e_pu_en, 6'h3b);
        rd(ppi_pkg::OFS_PIN_STATE, 32'h3b);
        wr(ppi_pkg::OFS_GPIO_PU, 32'h0);
        settle();
        chk({can_tx_pu_en, can_tx_oe_n}, 2'h1);
        @(posedge aclk);
        can_tx_data <= 1'b0;
        settle();
        chk({can_tx_pu_en, can_tx_oe_n, can_tx_out}, 3'h0);
        wr(ppi_pkg::OFS_INT_MASK, 32'h3);
        req_run(0, 40.0, f, h);
        chk(f, 3);
        chk(h, 10);
        chk(irq, 1'b1);
        rd(ppi_pkg::OFS_INT_STAT, 32'h1);
        rd(ppi_pkg::OFS_INT_STAT, 32'h0);
        settle();
        chk(irq, 1'b0);
        wr(ppi_pkg::OFS_IRQ_CFG, 32'h2);
        req_run(1, 40.0, f, h);
        chk(f, 3);
        chk(h, 1);
        rd(ppi_pkg::OFS_INT_STAT, 32'h2);
        wr(ppi_pkg::OFS_INT_MASK, 32'h0);
        req_run(0, 20.0, f, h);
        chk(irq, 1'b0);
        rd(ppi_pkg::OFS_INT_STAT, 32'h1);
        @(posedge aclk);
        low_power <= 1'b1;
        @(negedge aclk);
        #1 far.pull(0, 20.0);
        #1 chk(ext_wake, 1'b1);
        repeat (8) @(posedge aclk);
        low_power <= 1'b0;
        wr(ppi_pkg::OFS_SYS_PUD, 32'h1);
        settle();
        chk(ext_request_pu_en, 1'b0);
        final_report();
    end
endmodule
